// ### hdl/kbsl_consts.svh
// Summary of operation
// - read 76 keys via five 16-input muxes
// - poll upper and lower bank via bank select
// - four-bit select picks switch on every mux
// - lower bank uses three senses, upper two
// - key data leaves serially on shared line
// - host sync pulses enter sync sense input
// - transfer only when host starts it
// - detect both sync edges, then acknowledge
// - send byte low nibble first, then high
// - no pending data: no ack, stay idle
`ifndef KBSL_CONSTS_SVH
`define KBSL_CONSTS_SVH
`define KBSL_CLK_MHZ 20
`define KBSL_SYNC_MIN_NS 10000
`define KBSL_SYNC_MIN_CYC ((`KBSL_SYNC_MIN_NS * `KBSL_CLK_MHZ + 999) / 1000)
`define KBSL_ACK_NS 5000
`define KBSL_ACK_CYC ((`KBSL_ACK_NS * `KBSL_CLK_MHZ + 999) / 1000)
`define KBSL_BIT_NS 20000
`define KBSL_BIT_CYC ((`KBSL_BIT_NS * `KBSL_CLK_MHZ + 999) / 1000)
`define KBSL_SETTLE_CYC 8
`define KBSL_FIFO_DEPTH 8
`define KBSL_KEYS 76
`endif

// ### hdl/kbsl_pkg.sv
package kbsl_pkg;
  // link sequencer states
  typedef enum logic [2:0] {
    KBSL_IDLE = 3'b000,
    KBSL_SYNC = 3'b001,
    KBSL_ACK = 3'b010,
    KBSL_GAP = 3'b011,
    KBSL_BITS = 3'b100
  } kbsl_state_t;
  // scan outputs toward the mux banks
  typedef struct packed {
    logic bank_select_line;
    logic [3:0] switch_select_outputs;
  } kbsl_scan_t;
endpackage

// ### hdl/kbsl_fifo.sv
`timescale 1ns/10ps
// small synchronous fifo, one word per cycle each side
module kbsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wr_ptr; // write index
  logic [AW-1:0] rd_ptr; // read index
  logic [AW:0] count; // words held
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // kbsl_fifo

// ### hdl/kbsl_keyboard.sv
`timescale 1ns/10ps
`include "kbsl_consts.svh"
// keyboard side: scans the key matrix, queues key events, answers syncs
module kbsl_keyboard #(
  parameter int SYNC_MIN_CYC = `KBSL_SYNC_MIN_CYC,
  parameter int ACK_CYC = `KBSL_ACK_CYC,
  parameter int BIT_CYC = `KBSL_BIT_CYC,
  parameter int SETTLE_CYC = `KBSL_SETTLE_CYC,
  parameter int FIFO_DEPTH = `KBSL_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  output kbsl_pkg::kbsl_scan_t scan,
  input wire logic [2:0] key_sense_inputs,
  input wire logic sync_sense_input,
  output logic serial_key_output,
  output logic line_oe,
  output logic overflow
);
  localparam int CW = 16;
  // scan and link state in one struct; synchronisers and fifo sit outside it
  typedef struct packed {
    kbsl_pkg::kbsl_state_t st;
    kbsl_pkg::kbsl_scan_t scan;
    logic [CW-1:0] settle; // mux settle counter
    logic [15:0] bank_lo; // last seen key states, lower bank, per sense
    logic [15:0] bank_lo2;
    logic [15:0] bank_lo3;
    logic [15:0] bank_up2; // upper bank, second and third sense
    logic [15:0] bank_up3;
    logic [CW-1:0] tmr; // link timer
    logic [2:0] bit_idx; // bit within the byte
    logic [7:0] shreg; // byte being sent
    logic line_low; // pull line low
    logic overflow;
  } kbsl_regs_t;
  kbsl_regs_t r;
  kbsl_regs_t next_r;
  // sample point in quarter steps; the sense pin synchroniser uses two of it
  localparam logic [CW-3:0] SETTLE_Q = (CW-2)'(SETTLE_CYC / 4);
  logic settle_done; // sense lines settled for this switch
  assign settle_done = (r.settle[CW-1:2] == SETTLE_Q);
  logic [1:0] sync_meta; // two-flop synchroniser for the line
  logic [2:0] sense_meta; // first stage for the mux sense pins
  logic [2:0] sense_sync; // second stage, the only one logic reads
  logic line_in; // synchronised line level
  logic line_prev; // for edge detection
  logic [7:0] ev_data; // key event toward fifo
  logic ev_valid;
  logic ev_ready;
  logic [7:0] q_data;
  logic q_valid;
  logic q_pop;
  assign line_in = sync_meta[1];
  // line synchroniser; only second stage is read by logic
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_meta <= 2'h3;
      line_prev <= 1'b1;
      sense_meta <= 3'h0;
      sense_sync <= 3'h0;
    end else begin
      sync_meta <= {sync_meta[0], sync_sense_input};
      line_prev <= line_in;
      // mux outputs are asynchronous pins; costs two cycles of settle
      sense_meta <= key_sense_inputs;
      sense_sync <= sense_meta;
    end
  end
  // event queue; a full queue stalls the scan so no change is lost
  kbsl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(ev_data),
    .in_valid(ev_valid),
    .in_ready(ev_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_pop)
  );
  logic sense_prev; // stored state for the current key
  logic sense_now; // current sampled state
  logic key_ok; // this position maps to a real key
  logic [1:0] sel_line;
  // pick which sense line and stored bit belong to this scan step
  always_comb begin
    sel_line = r.settle[1:0];
    key_ok = 1'b1;
    sense_now = 1'b0;
    sense_prev = 1'b0;
    if (!r.scan.bank_select_line) begin
      unique case (sel_line)
        2'h0: begin
          sense_now = sense_sync[0];
          sense_prev = r.bank_lo[r.scan.switch_select_outputs];
        end
        2'h1: begin
          sense_now = sense_sync[1];
          sense_prev = r.bank_lo2[r.scan.switch_select_outputs];
        end
        2'h2: begin
          sense_now = sense_sync[2];
          sense_prev = r.bank_lo3[r.scan.switch_select_outputs];
        end
        2'h3: key_ok = 1'b0;
      endcase
    end else begin
      // upper bank has no first sense line
      unique case (sel_line)
        2'h1: begin
          sense_now = sense_sync[1];
          sense_prev = r.bank_up2[r.scan.switch_select_outputs];
        end
        2'h2: begin
          sense_now = sense_sync[2];
          sense_prev = r.bank_up3[r.scan.switch_select_outputs];
        end
        default: key_ok = 1'b0;
      endcase
    end
    // key code: bank, sense line, switch; msb is up/down polarity
    ev_data = {sense_now, r.scan.bank_select_line, sel_line,
               r.scan.switch_select_outputs};
    ev_valid = key_ok && settle_done && (sense_now != sense_prev);
  end
  // next-state logic for scan and link
  always_comb begin
    next_r = r;
    q_pop = 1'b0;
    // scan: settle, sample each sense line, then step the switch select
    if (!(ev_valid && !ev_ready)) begin
      if (settle_done && sel_line == 2'h3) begin
        next_r.settle = '0;
        next_r.scan.switch_select_outputs =
          r.scan.switch_select_outputs + 4'h1;
        if (r.scan.switch_select_outputs == 4'hF) begin
          next_r.scan.bank_select_line =
            ~r.scan.bank_select_line;
        end
      end else begin
        next_r.settle = r.settle + CW'(1);
      end
      if (key_ok && settle_done) begin
        // record new state of this key, five muxes overall
        unique case ({r.scan.bank_select_line, sel_line})
          3'h0: next_r.bank_lo[r.scan.switch_select_outputs] = sense_now;
          3'h1: next_r.bank_lo2[r.scan.switch_select_outputs] = sense_now;
          3'h2: next_r.bank_lo3[r.scan.switch_select_outputs] = sense_now;
          3'h5: next_r.bank_up2[r.scan.switch_select_outputs] = sense_now;
          3'h6: next_r.bank_up3[r.scan.switch_select_outputs] = sense_now;
          default: ;
        endcase
      end
    end
    // sticky overflow if a key change waits on a full queue
    if (ev_valid && !ev_ready) begin
      next_r.overflow = 1'b1;
    end
    next_r.tmr = r.tmr + CW'(1);
    unique case (r.st)
      kbsl_pkg::KBSL_IDLE: begin
        // wait for host to pull line low; never start alone
        if (line_prev && !line_in) begin
          next_r.st = kbsl_pkg::KBSL_SYNC;
          // the first low cycle has already passed the synchroniser
          next_r.tmr = CW'(1);
        end
      end
      kbsl_pkg::KBSL_SYNC: begin
        // rising edge ends sync; short glitches are ignored
        if (!line_prev && line_in) begin
          if (r.tmr >= CW'(SYNC_MIN_CYC) && q_valid) begin
            next_r.st = kbsl_pkg::KBSL_ACK;
            next_r.tmr = '0;
            next_r.line_low = 1'b1;
            next_r.shreg = q_data;
            q_pop = 1'b1;
          end else begin
            next_r.st = kbsl_pkg::KBSL_IDLE;
          end
        end
      end
      kbsl_pkg::KBSL_ACK: begin
        if (r.tmr == CW'(ACK_CYC - 1)) begin
          next_r.line_low = 1'b0;
          next_r.st = kbsl_pkg::KBSL_GAP;
          next_r.tmr = '0;
        end
      end
      kbsl_pkg::KBSL_GAP: begin
        if (r.tmr == CW'(BIT_CYC - 1)) begin
          next_r.st = kbsl_pkg::KBSL_BITS;
          next_r.tmr = '0;
          next_r.bit_idx = 3'h0;
          next_r.line_low = ~r.shreg[0];
        end
      end
      kbsl_pkg::KBSL_BITS: begin
        // lsb first: low nibble goes out before high nibble
        if (r.tmr == CW'(BIT_CYC - 1)) begin
          next_r.tmr = '0;
          if (r.bit_idx == 3'h7) begin
            next_r.line_low = 1'b0;
            next_r.st = kbsl_pkg::KBSL_IDLE;
          end else begin
            next_r.bit_idx = r.bit_idx + 3'h1;
            next_r.line_low = ~r.shreg[r.bit_idx + 3'h1];
          end
        end
      end
      default: next_r.st = kbsl_pkg::KBSL_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // line only ever pulled low or released
  assign serial_key_output = 1'b0;
  assign line_oe = r.line_low;
  assign scan = r.scan;
  assign overflow = r.overflow;
endmodule // kbsl_keyboard

// ### bench/kbsl_properties.sv
`timescale 1ns/10ps
// watch on the key line and scan pins
module kbsl_properties #(
  parameter int SYNC_MIN_CYC = 4,
  parameter int ACK_CYC = 2,
  parameter int BIT_CYC = 4,
  parameter int SETTLE_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire kbsl_pkg::kbsl_scan_t scan,
  input wire logic sync_sense_input,
  input wire logic serial_key_output,
  input wire logic line_oe,
  input wire logic overflow
);
  // released/pulled samples, since rise, low stretch, switch age
  int idle, run, rise, low, last, age;
  logic start; // pull after long quiet: an ack
  assign start = line_oe && idle >= 10 * BIT_CYC;
  // idle and rise saturate, so a long idle never wraps
  always_ff @(posedge clk) begin
    idle <= rst ? 999 : line_oe ? 0 : idle + int'(idle < 999);
    run <= rst || !line_oe ? 0 : run + 1;
    rise <= rst || $rose(sync_sense_input) ? 0 : rise + int'(rise < 99);
    low <= rst || sync_sense_input ? 0 : low + 1;
    last <= $rose(sync_sense_input) ? low : last;
    age <= rst || $changed(scan.switch_select_outputs) ? 0 : age + 1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  open_drain_a: assert property (serial_key_output == 1'b0)
    else $error("line data not low");
  host_started_a: assert property (start |-> rise <= 6)
    else $error("sent without a sync");
  sync_length_a: assert property (start |-> last >= SYNC_MIN_CYC)
    else $error("ack after short sync");
  pulse_width_a: assert property (
    $fell(line_oe) |-> run == ACK_CYC || run % BIT_CYC == 0)
    else $error("bad pulled width");
  quiet_width_a: assert property (
    $rose(line_oe) && idle < 10 * BIT_CYC |-> idle % BIT_CYC == 0)
    else $error("bad released width");
  byte_bound_a: assert property (line_oe |-> run < 8 * BIT_CYC)
    else $error("pulled past one byte");
  reset_release_a: assert property (
    disable iff (1'b0) rst |=> !line_oe) else $error("line held in reset");
  scan_settle_a: assert property (
    $changed(scan.switch_select_outputs) |-> age >= SETTLE_CYC)
    else $error("select moved early");
  cover property (start);
  cover property ($fell(line_oe) && run == ACK_CYC);
  cover property ($rose(overflow));
endmodule // kbsl_properties
bind kbsl_keyboard kbsl_properties #(.SYNC_MIN_CYC(SYNC_MIN_CYC),
  .ACK_CYC(ACK_CYC), .BIT_CYC(BIT_CYC), .SETTLE_CYC(SETTLE_CYC)) chk (
  .clk(clk), .rst(rst), .scan(scan), .sync_sense_input(sync_sense_input),
  .serial_key_output(serial_key_output), .line_oe(line_oe),
  .overflow(overflow));

// ### bench/kbsl_host_model.sv
`timescale 1ns/10ps
// host end of the key line: starts each transfer, reads the byte
module kbsl_host_model #(
  parameter int BIT_CYC = 4
) (
  input wire logic clk,
  input wire logic line,
  output logic pull
);
  initial pull = 1'b0; // released, pull-up holds it high
  // sync pulse, wait for an ack, sample each bit mid-cell
  task automatic xfer(input int low_cyc, output bit ack,
    output logic [7:0] data);
    int n;
    ack = 1'b0;
    data = 8'h00;
    @(posedge clk);
    pull <= 1'b1;
    repeat (low_cyc) @(posedge clk);
    pull <= 1'b0;
    for (n = 0; n < 12 && !ack; n++) begin
      @(posedge clk);
      ack = !line;
    end
    // skip the ack, the released gap and half a cell
    for (n = 0; n < 12 && ack && !line; n++) @(posedge clk);
    if (ack) repeat (BIT_CYC + BIT_CYC / 2 - 1) @(posedge clk);
    for (n = 0; n < 8 && ack; n++) begin
      data[n] = line;
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
endmodule // kbsl_host_model

// ### bench/test_keyboard_scan_sync_link.sv
`timescale 1ns/10ps
// bench: key matrix, host model, queue of owed key bytes
module test_keyboard_scan_sync_link;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sense = 3'h0; // mux outputs
  logic pull, line_oe, sdo, ovf;
  wire line; // shared line, pulled up
  kbsl_pkg::kbsl_scan_t scan;
  bit keys [0:1][0:2][0:15]; // switch states
  logic [7:0] exp_q [$]; // bytes owed to the host
  int fail_count = 0;
  int cmp_count = 0;
  int i;
  assign line = !(pull || (line_oe === 1'b1 && sdo === 1'b0));
  always #25 clk = ~clk;
  kbsl_keyboard #(.SYNC_MIN_CYC(4), .ACK_CYC(2), .BIT_CYC(4),
    .SETTLE_CYC(8)) DUT (.clk(clk), .rst(rst),
    .scan(scan), .key_sense_inputs(sense), .sync_sense_input(line),
    .serial_key_output(sdo), .line_oe(line_oe), .overflow(ovf));
  kbsl_host_model #(.BIT_CYC(4)) host (.clk(clk), .line(line), .pull(pull));
  // mux banks answer the selected switch a clock late
  function automatic bit key(input int s);
    return keys[scan.bank_select_line][s][scan.switch_select_outputs];
  endfunction
  always @(posedge clk) sense <= {key(2), key(1), key(0)};
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp({7'h00, got}, {7'h00, exp});
  endtask
  // one transfer, judged against the queue model
  task automatic sync(input int low);
    bit ack;
    logic [7:0] got;
    host.xfer(low, ack, got);
    if (low < 4 || exp_q.size() == 0) begin
      cmp_flag(ack, 1'b0);
    end else begin
      cmp_flag(ack, 1'b1);
      cmp(got, exp_q.pop_front());
    end
    repeat (50) @(posedge clk);
  endtask
  // flip one switch, then let a full scan of both banks pass
  task automatic toggle(input int b, input int s, input int w);
    #1;
    keys[b][s][w] = !keys[b][s][w];
    // upper bank has no first sense line
    if (b == 0 || s != 0) begin
      exp_q.push_back({keys[b][s][w], b[0], s[1:0], w[3:0]});
    end
    repeat (420) @(posedge clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(37));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (400) @(posedge clk);
    cmp_flag(ovf, 1'b0);
    sync(8);
    $display("test empty queue done");
    toggle(0, 2, 15);
    sync(3);
    sync(4);
    $display("test short sync done");
    for (i = 0; i < 12; i++) begin
      toggle($urandom % 2, $urandom % 3, $urandom % 16);
      sync(6 + $urandom % 30);
    end
    $display("test random keys done");
    // queue fills, scan stalls, then drains to empty
    for (i = 0; i < 10; i++) toggle(0, i % 3, i);
    cmp_flag(ovf, 1'b1);
    for (i = 0; i < 11; i++) sync(8);
    cmp_flag(ovf, 1'b1);
    $display("test full queue done");
    final_report();
  end
  // hang guard, about twice the planned run
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule // test_keyboard_scan_sync_link
